// ==== rtl/ccdfe_device.sv ====
`timescale 1ns/10ps
// Overview of operation
// - Output bits change on conversion clock rise
// - Latency ten correlated, nine direct mode
// - Direct mode samples input every rising edge
// - Black window is cycles five to twelve
// - Clamp reference is window sum over eight; correlated mode sums pulse cycles plus cycle twelve
// - Output disable pin high floats outputs
// - Low three bits select register
// - Register 0 holds eight-bit gain
// - Register 0 bit 15 selects input path
// - Register 1 bits 5-7 alter output code
// - Hold-amp bandwidth never written zero
// - Controller never writes test registers 4-7
// - Polarity bit sets sampling pulse sense
// - Sampling pulses quarter period, half apart
// - Sixteen serial clocks; aborted words discarded
// - Sleep and standby bits stop conversion
// - Black code equals twice field plus 14
// - Register 2 bit 15 low resets the data path, not the registers
module ccdfe_device
(
   input wire logic clk,
   input wire logic nrst,
   ccdfe_if.dev link,
   output logic [7:0] gain,
   output logic [1:0] holdAmpBandwidth,
   output logic [3:0] blackHoldTimeConst,
   output logic [15:0] codingCtrl,
   output logic sleeping
);
   logic [15:0] reg0, reg1, reg2, reg3;
   logic [15:0] next_reg0, next_reg1, next_reg2, next_reg3;
   logic [15:0] shiftReg, next_shiftReg;
   logic [4:0] bitCnt, next_bitCnt;
   logic sckD, next_sckD;
   logic [9:0] pipe [0:9];
   logic [9:0] next_pipe [0:9];
   logic [9:0] dataOutR, next_dataOutR;
   logic [3:0] obCnt, next_obCnt;
   logic obActive, next_obActive;
   logic [12:0] obSum, next_obSum;
   logic [9:0] clampRef, next_clampRef;
   logic obpD, next_obpD;
   logic runOk, polNormal, blkSeen, sigSeen, obpSeen, preblank_input;
   logic [9:0] sample, clampCode, codeOut;

   // Inverts a pulse when the polarity bit asks for the inverted sense
   function automatic logic polarize(input logic pin, input logic normal);
      polarize = normal ? pin : ~pin;
   endfunction

   // Bit written low keeps the nominal active-low sense
   assign polNormal = ~reg2[ccdfe_pkg::POL_BIT];
   // Nominal pulses are active low; the polarity bit flips all three
   assign blkSeen = ~polarize(link.blackSamplePulse, polNormal);
   assign sigSeen = ~polarize(link.signalSamplePulse, polNormal);
   assign preblank_input = ~polarize(link.preblankInput, polNormal);
   assign obpSeen = link.opticalBlackPulse;
   assign runOk = reg2[ccdfe_pkg::SWRST_BIT]
      & ~reg1[ccdfe_pkg::SLEEP_BIT] & ~reg1[ccdfe_pkg::REFERENCE_ONLY_STANDBY_BIT];
   // Clamp code from the five-bit field
   assign clampCode = 10'(reg2[ccdfe_pkg::CLAMP_LSB +: 5]) * 10'h002
      + ccdfe_pkg::CLAMP_OFS;

   // Serial receiver; sampled on serial clock rise, word kept only at 16
   always_comb
   begin
      next_shiftReg = shiftReg;
      next_bitCnt = bitCnt;
      next_sckD = link.serialClk;
      next_reg0 = reg0;
      next_reg1 = reg1;
      next_reg2 = reg2;
      next_reg3 = reg3;
      if (link.serialCsN)
      begin
         if (bitCnt == 5'h10)
         begin
            unique case (shiftReg[2:0])
               ccdfe_pkg::SEL_REG0: next_reg0 = shiftReg;
               ccdfe_pkg::SEL_REG1: next_reg1 = shiftReg;
               ccdfe_pkg::SEL_REG2: next_reg2 = shiftReg;
               ccdfe_pkg::SEL_REG3: next_reg3 = shiftReg;
               default: ; // Test registers are ignored
            endcase
         end
         next_bitCnt = 5'h00;
      end
      else if (link.serialClk && !sckD && bitCnt != 5'h1f)
      begin
         // MSB first
         next_shiftReg = {shiftReg[14:0], link.serialDataPin};
         next_bitCnt = bitCnt + 5'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         shiftReg <= 16'h0000;
         bitCnt <= 5'h00;
         sckD <= 1'b0;
         reg0 <= ccdfe_pkg::REG0_RST;
         reg1 <= ccdfe_pkg::REG1_RST;
         reg2 <= ccdfe_pkg::REG2_RST;
         reg3 <= ccdfe_pkg::REG3_RST;
      end
      else
      begin
         shiftReg <= next_shiftReg;
         bitCnt <= next_bitCnt;
         sckD <= next_sckD;
         reg0 <= next_reg0;
         reg1 <= next_reg1;
         reg2 <= next_reg2;
         reg3 <= next_reg3;
      end
   end

   // Sample selection, black window averaging and output pipeline
   always_comb
   begin
      for (int i = 0; i < 10; i++)
      begin
         next_pipe[i] = pipe[i];
      end
      next_obpD = obpSeen;
      next_obCnt = obCnt;
      next_obActive = obActive;
      next_obSum = obSum;
      next_clampRef = clampRef;
      codeOut = 10'h000;
      // Either path sampled each rise; pulses only gate the black window sum
      sample = reg0[ccdfe_pkg::PATH_BIT] ? link.directConverterInput
         : link.correlatedSamplingInput;
      if (obpSeen && !obpD)
      begin
         next_obActive = 1'b1;
         next_obCnt = 4'h0;
         next_obSum = 13'h0000;
      end
      else if (obActive)
      begin
         next_obCnt = obCnt + 4'h1;
         if (obCnt + 4'h1 >= ccdfe_pkg::OB_FIRST
            && obCnt + 4'h1 <= ccdfe_pkg::OB_LAST && blkSeen | sigSeen
            | reg0[ccdfe_pkg::PATH_BIT])
         begin
            next_obSum = obSum + 13'(sample);
         end
         if (obCnt + 4'h1 == ccdfe_pkg::OB_LAST)
         begin
            next_obActive = 1'b0;
            next_clampRef = 10'((obSum + 13'(sample)) >> 3);
         end
      end
      next_pipe[0] = sample;
      for (int i = 1; i < 10; i++)
      begin
         next_pipe[i] = pipe[i-1];
      end
      // Count runs from the sampling edge, so the output flop adds one
      codeOut = reg0[ccdfe_pkg::PATH_BIT]
         ? pipe[ccdfe_pkg::LAT_DIRECT - 1]
         : pipe[ccdfe_pkg::LAT_CDS - 1];
      if (reg1[ccdfe_pkg::TESTSEL_BIT])
      begin
         codeOut = codeOut ^ {1'b0, codeOut[9:1]};
      end
      if (preblank_input)
      begin
         codeOut = clampCode;
      end
      else
      begin
         if (reg1[ccdfe_pkg::INVA_BIT])
         begin
            codeOut[8:0] = ~codeOut[8:0];
         end
         if (reg1[ccdfe_pkg::INVB_BIT])
         begin
            codeOut[9] = ~codeOut[9];
         end
      end
      next_dataOutR = runOk ? codeOut : 10'h000;
   end

   // Everything here moves on the conversion clock rise
   always_ff @(posedge clk)
   begin
      if (!nrst || !reg2[ccdfe_pkg::SWRST_BIT])
      begin
         for (int i = 0; i < 10; i++)
         begin
            pipe[i] <= 10'h000;
         end
         dataOutR <= 10'h000;
         obCnt <= 4'h0;
         obActive <= 1'b0;
         obSum <= 13'h0000;
         clampRef <= 10'h000;
         obpD <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < 10; i++)
         begin
            pipe[i] <= next_pipe[i];
         end
         dataOutR <= next_dataOutR;
         obCnt <= next_obCnt;
         obActive <= next_obActive;
         obSum <= next_obSum;
         clampRef <= next_clampRef;
         obpD <= next_obpD;
      end
   end

   assign link.dataOut = dataOutR;
   assign link.dataOutEn = {10{~link.outputDisable}};
   assign gain = reg0[ccdfe_pkg::GAIN_LSB +: 8];
   assign holdAmpBandwidth = reg1[ccdfe_pkg::HOLDBW_LSB +: 2];
   assign blackHoldTimeConst = reg1[ccdfe_pkg::HOLDTC_LSB +: 4];
   assign codingCtrl = reg3;
   assign sleeping = ~runOk;
endmodule

// ==== rtl/ccdfe_pkg.sv ====
package ccdfe_pkg;
   // Serial word layout
   localparam int WORD_BITS = 16;
   localparam int SEL_LSB = 0;
   localparam logic [2:0] SEL_REG0 = 3'h0;
   localparam logic [2:0] SEL_REG1 = 3'h1;
   localparam logic [2:0] SEL_REG2 = 3'h2;
   localparam logic [2:0] SEL_REG3 = 3'h3;
   localparam int SEL_TEST_BIT = 2;
   // Register 0 fields
   localparam int GAIN_LSB = 5;
   localparam int PATH_BIT = 15;
   // Register 1 fields
   localparam int SLEEP_BIT = 3;
   localparam int REFERENCE_ONLY_STANDBY_BIT = 4;
   localparam int INVA_BIT = 5;
   localparam int INVB_BIT = 6;
   localparam int TESTSEL_BIT = 7;
   localparam int HOLDBW_LSB = 8;
   localparam int HOLDTC_LSB = 10;
   // Register 2 fields
   localparam int CLAMP_LSB = 3;
   localparam int POL_BIT = 13;
   localparam int SWRST_BIT = 15;
   // Reset values of the four registers
   localparam logic [15:0] REG0_RST = 16'h0000;
   localparam logic [15:0] REG1_RST = 16'h0100;
   localparam logic [15:0] REG2_RST = 16'h8048;
   localparam logic [15:0] REG3_RST = 16'h0000;
   // Clamp code = field*2 + offset
   localparam logic [9:0] CLAMP_OFS = 10'h00e;
   // Pipeline latencies
   localparam int LAT_CDS = 10;
   localparam int LAT_DIRECT = 9;
   // Black window: cycles 5..12 after the pulse
   localparam logic [3:0] OB_FIRST = 4'h5;
   localparam logic [3:0] OB_LAST = 4'hc;
   // Serial clock divider: 10 MHz / 4 = 2.5 MHz, under the 5 MHz limit
   localparam logic [1:0] SCK_DIV = 2'h1;
   // Host register offsets (APB byte addresses)
   localparam logic [7:0] H_DATA = 8'h00;
   localparam logic [7:0] H_CTRL = 8'h04;
   localparam logic [7:0] H_STAT = 8'h08;
   localparam logic [7:0] H_PINS = 8'h0c;
endpackage

// ==== rtl/ccdfe_if.sv ====
`timescale 1ns/10ps
// Link between timing generator/controller and the converter front end
interface ccdfe_if;
   logic [9:0] dataOut;
   logic [9:0] dataOutEn;
   logic outputDisable;
   logic blackSamplePulse;
   logic signalSamplePulse;
   logic preblankInput;
   logic opticalBlackPulse;
   logic [9:0] directConverterInput;
   logic [9:0] correlatedSamplingInput;
   logic serialCsN;
   logic serialClk;
   logic serialDataPin;
   modport dev
   (
      output dataOut, dataOutEn,
      input outputDisable, blackSamplePulse, signalSamplePulse,
      input preblankInput, opticalBlackPulse, directConverterInput,
      input correlatedSamplingInput, serialCsN, serialClk, serialDataPin
   );
   modport host
   (
      input dataOut, dataOutEn,
      output outputDisable, blackSamplePulse, signalSamplePulse,
      output preblankInput, opticalBlackPulse, directConverterInput,
      output correlatedSamplingInput, serialCsN, serialClk, serialDataPin
   );
endinterface

// ==== rtl/ccdfe_host.sv ====
`timescale 1ns/10ps
// Timing generator and serial controller, software-driven over APB
module ccdfe_host
(
   input wire logic clk,
   input wire logic nrst,
   ccdfe_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [9:0] pixelIn
);
   logic [15:0] word, next_word;
   logic [15:0] shiftReg, next_shiftReg;
   logic [4:0] bitCnt, next_bitCnt;
   logic [1:0] divCnt, next_divCnt;
   logic sck, next_sck, csN, next_csN, busy, next_busy;
   logic [4:0] pins, next_pins;
   logic [9:0] lastCode, next_lastCode;
   logic [1:0] phase, next_phase;
   logic acc, wrOk;

   assign acc = psel & penable;
   // Test registers and zero bandwidth refused at the source
   assign wrOk = ~pwdata[ccdfe_pkg::SEL_TEST_BIT]
      && !(pwdata[2:0] == ccdfe_pkg::SEL_REG1
      && pwdata[ccdfe_pkg::HOLDBW_LSB +: 2] == 2'h0);

   // APB slave, serial shifter, pulse generator
   always_comb
   begin
      next_word = word;
      next_shiftReg = shiftReg;
      next_bitCnt = bitCnt;
      next_divCnt = divCnt;
      next_sck = sck;
      next_csN = csN;
      next_busy = busy;
      next_pins = pins;
      next_lastCode = link.dataOutEn[0] ? link.dataOut : lastCode;
      next_phase = phase + 2'h1;
      if (acc && pwrite && paddr == ccdfe_pkg::H_DATA && !busy && wrOk)
      begin
         next_word = pwdata[15:0];
         next_shiftReg = pwdata[15:0];
         next_busy = 1'b1;
         next_csN = 1'b0;
         next_bitCnt = 5'h00;
         next_divCnt = 2'h0;
         next_sck = 1'b0;
      end
      else if (acc && pwrite && paddr == ccdfe_pkg::H_PINS)
      begin
         next_pins = pwdata[4:0];
      end
      else if (busy)
      begin
         next_divCnt = divCnt + 2'h1;
         if (divCnt == ccdfe_pkg::SCK_DIV)
         begin
            next_divCnt = 2'h0;
            if (bitCnt == 5'h10)
            begin
               next_csN = 1'b1;
               next_busy = 1'b0;
            end
            else if (!sck)
            begin
               next_sck = 1'b1;
            end
            else
            begin
               next_sck = 1'b0;
               next_shiftReg = {shiftReg[14:0], 1'b0};
               next_bitCnt = bitCnt + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         word <= 16'h0000;
         shiftReg <= 16'h0000;
         bitCnt <= 5'h00;
         divCnt <= 2'h0;
         sck <= 1'b0;
         csN <= 1'b1;
         busy <= 1'b0;
         pins <= 5'h00;
         lastCode <= 10'h000;
         phase <= 2'h0;
      end
      else
      begin
         word <= next_word;
         shiftReg <= next_shiftReg;
         bitCnt <= next_bitCnt;
         divCnt <= next_divCnt;
         sck <= next_sck;
         csN <= next_csN;
         busy <= next_busy;
         pins <= next_pins;
         lastCode <= next_lastCode;
         phase <= next_phase;
      end
   end

   // Read mux; slave always answers in the access cycle
   always_comb
   begin
      unique case (paddr)
         ccdfe_pkg::H_DATA: prdata = {16'h0000, word};
         ccdfe_pkg::H_CTRL: prdata = {31'h0, busy};
         ccdfe_pkg::H_STAT: prdata = {22'h0, lastCode};
         ccdfe_pkg::H_PINS: prdata = {27'h0, pins};
         default: prdata = 32'h00000000;
      endcase
   end
   assign pready = 1'b1;
   assign pslverr = acc && (paddr > ccdfe_pkg::H_PINS
      || (pwrite && paddr == ccdfe_pkg::H_DATA && (busy || !wrOk)));

   // Quarter-period low pulses, half a period apart (4 phases of clk)
   assign link.blackSamplePulse = ~(phase == 2'h0);
   assign link.signalSamplePulse = ~(phase == 2'h2);
   assign link.outputDisable = pins[0];
   assign link.preblankInput = ~pins[1];
   assign link.opticalBlackPulse = pins[2];
   assign link.directConverterInput = pixelIn;
   assign link.correlatedSamplingInput = pixelIn;
   assign link.serialCsN = csN;
   assign link.serialClk = sck;
   assign link.serialDataPin = shiftReg[15];
endmodule

// ==== dv/ccdfe_asserts.sv ====
`timescale 1ns/10ps
// Watches the serial control link and the data output enables
module ccdfe_asserts
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [9:0] dataOutEn,
   input wire logic outputDisable,
   input wire logic serialCsN,
   input wire logic serialClk,
   input wire logic serialDataPin
);
   logic sckQ;
   logic next_sckQ;
   logic [4:0] bitCnt;
   logic [4:0] next_bitCnt;
   logic [15:0] word;
   logic [15:0] next_word;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // Serial clock is made from clk, so an edge detect in clk is exact
   always_comb
   begin
      next_sckQ = serialClk;
      next_bitCnt = bitCnt;
      next_word = word;
      if (serialCsN)
         next_bitCnt = 5'h00;
      else if (serialClk && !sckQ)
      begin
         next_bitCnt = bitCnt + 5'h01;
         next_word = {word[14:0], serialDataPin};
      end
   end
   // No saturation: an overlong frame is itself the fault to catch
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sckQ <= 1'b0;
         bitCnt <= 5'h00;
         word <= 16'h0000;
      end
      else
      begin
         sckQ <= next_sckQ;
         bitCnt <= next_bitCnt;
         word <= next_word;
      end
   end
   AST_OE_OFF:
   assert property (outputDisable |-> dataOutEn == 10'h000)
      else $error("data outputs driven while disabled");
   AST_OE_ON:
   assert property (!outputDisable |-> dataOutEn == 10'h3ff)
      else $error("data outputs floating while enabled");
   AST_BIT_COUNT:
   assert property ($rose(serialCsN) |-> bitCnt == 5'h10)
      else $error("serial frame without sixteen clocks");
   AST_FRAME_END:
   assert property ($fell(serialCsN) |-> ##[32:100] serialCsN)
      else $error("serial frame length out of range");
   AST_SCK_IDLE:
   assert property (serialCsN && $past(serialCsN) |-> !serialClk)
      else $error("serial clock moving outside a frame");
   AST_NO_TEST_REG:
   assert property ($rose(serialCsN) |-> !word[2])
      else $error("test register addressed");
   AST_BW_LEGAL:
   assert property ($rose(serialCsN) && word[2:0] == 3'h1
      |-> word[9:8] != 2'h0)
      else $error("hold amp bandwidth written zero");
   AST_REG0_ZERO:
   assert property ($rose(serialCsN) && word[2:0] == 3'h0
      |-> {word[14:13], word[4:3]} == 4'h0)
      else $error("unused gain register bits set");
   cover property ($rose(serialCsN) && word[2:0] == 3'h0);
   cover property ($rose(serialCsN) && word[2:0] == 3'h2);
   cover property ($rose(outputDisable));
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
// Host and device joined over the link; software side driven over APB
module testbench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [9:0] pixelIn = 10'h000;
   logic [7:0] gain;
   logic [1:0] holdAmpBandwidth;
   logic [3:0] blackHoldTimeConst;
   logic [15:0] codingCtrl;
   logic sleeping;
   logic dirMode = 1'b0;
   logic [9:0] hist [0:10];
   logic [31:0] rd;
   logic err;
   int nFail = 0;
   int nTests = 0;
   ccdfe_if link();
   ccdfe_device u_ccdfe_device
   (
      .clk(clk),
      .nrst(nrst),
      .link(link),
      .gain(gain),
      .holdAmpBandwidth(holdAmpBandwidth),
      .blackHoldTimeConst(blackHoldTimeConst),
      .codingCtrl(codingCtrl),
      .sleeping(sleeping)
   );
   ccdfe_host u_ccdfe_host
   (
      .clk(clk),
      .nrst(nrst),
      .link(link),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .pixelIn(pixelIn)
   );
   ccdfe_asserts u_ccdfe_asserts
   (
      .clk(clk),
      .nrst(nrst),
      .dataOutEn(link.dataOutEn),
      .outputDisable(link.outputDisable),
      .serialCsN(link.serialCsN),
      .serialClk(link.serialClk),
      .serialDataPin(link.serialDataPin)
   );
   always #50 clk = ~clk;
   // Odd ramp step so every data bit toggles within 74 cycles
   always @(posedge clk)
      pixelIn <= pixelIn + 10'h007;
   // Sample history of the selected input path
   always @(posedge clk)
   begin
      hist[0] <= dirMode ? link.directConverterInput
         : link.correlatedSamplingInput;
      for (int i = 1; i < 11; i++)
         hist[i] <= hist[i - 1];
   end
   task automatic wrapUp();
      $display("Comparisons %0d, mismatches %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         nFail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1)
      begin
         nFail++;
         wrapUp();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Busy must clear before the next word; bounded poll
   task automatic waitIdle();
      int k = 0;
      do
      begin
         apb(1'b0, ccdfe_pkg::H_CTRL, 32'h0);
         k++;
      end
      while (rd[0] !== 1'b0 && k < 100);
      if (rd[0] !== 1'b0)
      begin
         nFail++;
         wrapUp();
      end
      repeat (4) @(posedge clk);
   endtask
   task automatic sw(input logic [15:0] w);
      apb(1'b1, ccdfe_pkg::H_DATA, {16'h0000, w});
      chk({31'h0, err}, 32'h0);
      waitIdle();
   endtask
   task automatic lat(input int n, input logic [9:0] x);
      repeat (14) @(posedge clk);
      repeat (8)
      begin
         @(negedge clk);
         chk({22'h0, link.dataOut}, {22'h0, hist[n] ^ x});
      end
   endtask
   task automatic testPath();
      @(negedge clk);
      chk({2'h0, gain, holdAmpBandwidth, blackHoldTimeConst, codingCtrl},
         32'h0010_0000);
      chk({31'h0, sleeping}, 32'h0);
      lat(10, 10'h000);
      apb(1'b1, ccdfe_pkg::H_DATA, 32'h0000_94a0);
      chk({24'h0, gain}, 32'h0);
      waitIdle();
      chk({24'h0, gain}, 32'h0000_00a5);
      dirMode <= 1'b1;
      lat(9, 10'h000);
   endtask
   task automatic testRegs();
      sw(16'h2b01);
      chk({18'h0, gain, holdAmpBandwidth, blackHoldTimeConst},
         32'h0000_297a);
      sw(16'h104b);
      chk({19'h0, codingCtrl[15:3]}, 32'h0000_0209);
      apb(1'b1, ccdfe_pkg::H_DATA, 32'h0000_0004);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, ccdfe_pkg::H_DATA, 32'h0000_0001);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, ccdfe_pkg::H_DATA, 32'h0000_2f01);
      apb(1'b1, ccdfe_pkg::H_DATA, 32'h0000_2b02);
      chk({31'h0, err}, 32'h1);
      waitIdle();
      chk({26'h0, holdAmpBandwidth, blackHoldTimeConst}, 32'h3b);
   endtask
   task automatic testInvert();
      logic [15:0] w [4] = '{16'h2f21, 16'h2f41, 16'h2f61, 16'h2f01};
      logic [9:0] x [4] = '{10'h1ff, 10'h200, 10'h3ff, 10'h000};
      // Test code select gives the gray form of the binary code
      sw(16'h2f81);
      repeat (14) @(posedge clk);
      repeat (8)
      begin
         @(negedge clk);
         chk({22'h0, link.dataOut}, {22'h0, hist[9] ^ (hist[9] >> 1)});
      end
      for (int i = 0; i < 4; i++)
      begin
         sw(w[i]);
         lat(9, x[i]);
      end
   endtask
   task automatic testPins();
      apb(1'b1, ccdfe_pkg::H_PINS, 32'h1);
      repeat (3) @(negedge clk);
      chk({22'h0, link.dataOutEn}, 32'h0);
      apb(1'b1, ccdfe_pkg::H_PINS, 32'h0);
      repeat (3) @(negedge clk);
      chk({22'h0, link.dataOutEn}, 32'h3ff);
      sw(16'h802a);
      apb(1'b1, ccdfe_pkg::H_PINS, 32'h2);
      repeat (14) @(negedge clk);
      chk({22'h0, link.dataOut}, 32'h2 * 32'h5 + 32'he);
      apb(1'b1, ccdfe_pkg::H_PINS, 32'h0);
      // Polarity bit high: an idle-high pin now reads as active
      sw(16'ha02a);
      repeat (14) @(negedge clk);
      chk({22'h0, link.dataOut}, 32'h2 * 32'h5 + 32'he);
      sw(16'h802a);
   endtask
   // Black window in direct mode: samples of edges five to twelve
   task automatic testBlack();
      int sum = 0;
      apb(1'b1, ccdfe_pkg::H_PINS, 32'h4);
      repeat (13) @(posedge clk);
      @(negedge clk);
      for (int i = 0; i < 8; i++)
         sum += hist[i];
      chk({22'h0, u_ccdfe_device.clampRef}, 32'(sum / 8));
      apb(1'b1, ccdfe_pkg::H_PINS, 32'h0);
   endtask
   // Soft reset last, since it clears the pipeline and clamp reference
   task automatic testPower();
      logic [15:0] w [4] = '{16'h2f09, 16'h2f11, 16'h2f01, 16'h002a};
      logic s [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 4; i++)
      begin
         sw(w[i]);
         repeat (12) @(negedge clk);
         chk({31'h0, sleeping}, {31'h0, s[i]});
         if (s[i])
            chk({22'h0, link.dataOut}, 32'h0);
      end
      sw(16'h802a);
      chk({31'h0, sleeping}, 32'h0);
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      testPath();
      testRegs();
      testInvert();
      testPins();
      testBlack();
      testPower();
      wrapUp();
   end
endmodule
